// ### design/evc_consts.svh
// Constants for the encoder velocity calculator: defaults, scales and timing.
`ifndef EVC_CONSTS_SVH
`define EVC_CONSTS_SVH

// Configuration defaults loaded at reset and on a restore request.
`define EVC_WINDOW_MS_DEF   16'h000A
`define EVC_NUMERATOR_DEF   32'h00000001
`define EVC_DENOMINATOR_DEF 32'h00000001
`define EVC_FILTER_DEF      4'h0
`define EVC_MAN_RES_DEF     32'h00000000
`define EVC_MAN_RES_EN_DEF  1'b0
// Power-of-two resolution in bits; the value is arbitrary.
`define EVC_RES_BITS_DEF    6'h19

// Nanoseconds in one millisecond, used to turn the window into cycle time units.
`define EVC_NS_PER_MS       40'h00000F4240
// Least bus cycle time in nanoseconds (1.2 ms) while velocity data is selected.
`define EVC_MIN_CYCLE_NS    32'h00124F80
// Strongest filter level.
`define EVC_FILTER_MAX      4'h8
// Steps of the serial divider, one per quotient bit.
`define EVC_DIV_STEPS       7'h48

`endif

// ### design/evc_pkg.sv
// Types shared by the encoder velocity calculator.
package evc_pkg;

    // Configuration set written by the parameter side in one strobe.
    typedef struct packed {
        logic [15:0] window_ms;
        logic [31:0] numerator;
        logic [31:0] denominator;
        logic [3:0]  filter_sel;
        logic [31:0] manual_res;
        logic        manual_res_en;
        logic [5:0]  res_bits;
    } evc_cfg_t;

    // Scaling engine state.
    typedef enum logic [0:0] {
        EVC_ST_IDLE = 1'b0,
        EVC_ST_DIV  = 1'b1
    } evc_state_t;

endpackage : evc_pkg

// ### design/evc_velocity_calc.sv
// Encoder velocity calculator with window, scaling and recursive low-pass filter.
`timescale 1ns/1ns
`include "evc_consts.svh"

// Contract
// RULE1 - Velocity is the position change over the window, published on the velocity output.
// RULE2 - Window length is configurable and defaults to ten milliseconds after reset or restore.
// RULE3 - Window spans whole bus cycles, rounded up to the next cycle.
// RULE4 - Raw velocity is multiplied by the numerator and divided by the denominator.
// RULE5 - A manually entered encoder resolution is held for non power-of-two encoders.
// RULE6 - Manual resolution is used only while its enable flag is set.
// RULE7 - Filter selector defaults to zero, and zero passes velocity unfiltered.
// RULE8 - Level n filter: out = in*a0 + previous*(1-a0), a0 = 2^-n.
// RULE9 - The filter advances one step per bus cycle.
// RULE10 - The master runs a bus cycle of at least 1.2 ms here.
// RULE11 - Velocity logic ignores synchronisation mode and behaves the same in all modes.
// RULE12 - Position is sampled exactly once per bus cycle.
// RULE13 - Position difference wraps modulo the active resolution to a signed delta.
module evc_velocity_calc
    import evc_pkg::*;
(
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic               cycle_strobe_i,
    input  wire logic [31:0]        position_i,
    input  wire logic [31:0]        cycle_ns_i,
    input  wire logic               cfg_we_i,
    input  wire evc_cfg_t           cfg_i,
    input  wire logic               restore_i,
    output evc_cfg_t                cfg_o,
    output logic signed [31:0]      velocity_o,
    output logic                    velocity_valid_o,
    output logic                    cycle_short_o
);

    localparam evc_cfg_t CFG_DEF = '{
        window_ms:     `EVC_WINDOW_MS_DEF,
        numerator:     `EVC_NUMERATOR_DEF,
        denominator:   `EVC_DENOMINATOR_DEF,
        filter_sel:    `EVC_FILTER_DEF,
        manual_res:    `EVC_MAN_RES_DEF,
        manual_res_en: `EVC_MAN_RES_EN_DEF,
        res_bits:      `EVC_RES_BITS_DEF
    };

    evc_cfg_t            cfg_r;
    logic [31:0]         prev_pos_r;
    logic                have_prev_r;
    logic signed [39:0]  acc_r;
    logic [39:0]         elapsed_r;
    evc_state_t          state_r;
    logic [6:0]          step_r;
    logic [32:0]         rem_r;
    logic [71:0]         quo_r;
    logic                neg_r;
    logic signed [31:0]  scaled_r;
    logic                short_r;

    logic [39:0]         res_w;
    logic [39:0]         half_w;
    logic signed [39:0]  diff_w;
    logic signed [39:0]  delta_w;
    logic [39:0]         window_ns_w;
    logic [39:0]         elapsed_nxt;
    logic                close_w;
    logic signed [39:0]  sum_w;
    logic [39:0]         sum_mag_w;
    logic [31:0]         den_w;
    logic [32:0]         rem_sh_w;
    logic [3:0]          level_w;
    logic signed [32:0]  filt_diff_w;
    logic signed [32:0]  filt_nxt;

    assign cfg_o = cfg_r;

    // Configuration store; a restore request wins over a write in the same cycle.
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cfg_r <= CFG_DEF; // RULE2 RULE7
        end
        else if (restore_i)
        begin
            cfg_r <= CFG_DEF; // RULE2 RULE7
        end
        else if (cfg_we_i)
        begin
            cfg_r <= cfg_i; // RULE5
        end
    end

    // Active resolution; a zero manual value falls back to the power-of-two one.
    always_comb
    begin
        if (cfg_r.manual_res_en && (cfg_r.manual_res != 32'h00000000))
        begin
            res_w = {8'h00, cfg_r.manual_res}; // RULE6
        end
        else
        begin
            res_w = 40'h0000000001 << cfg_r.res_bits; // RULE6
        end
        half_w = res_w >> 1;
    end

    // Signed delta folded into half a revolution either way, so a wrap reads as a small step.
    always_comb
    begin
        diff_w = $signed({8'h00, position_i}) - $signed({8'h00, prev_pos_r});
        if (!have_prev_r)
        begin
            delta_w = 40'sh0000000000;
        end
        else if (diff_w >= $signed(half_w))
        begin
            delta_w = diff_w - $signed(res_w); // RULE13
        end
        else if (diff_w < -$signed(half_w))
        begin
            delta_w = diff_w + $signed(res_w); // RULE13
        end
        else
        begin
            delta_w = diff_w;
        end
    end

    // Window closes on the first cycle whose summed time reaches the window, so it rounds up.
    assign window_ns_w = 40'({24'h000000, cfg_r.window_ms} * `EVC_NS_PER_MS);
    assign elapsed_nxt = elapsed_r + {8'h00, cycle_ns_i};
    assign close_w     = (elapsed_nxt >= window_ns_w); // RULE3
    assign sum_w       = acc_r + delta_w; // RULE1
    assign sum_mag_w   = sum_w[39] ? 40'(-sum_w) : 40'(sum_w);

    // Position is taken only on the bus cycle strobe; no other sample exists.
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            prev_pos_r  <= 32'h00000000;
            have_prev_r <= 1'b0;
        end
        else if (cycle_strobe_i)
        begin
            prev_pos_r  <= position_i; // RULE12
            have_prev_r <= 1'b1;
        end
    end

    // Window accumulator. Nothing here looks at synchronisation mode, so every mode is alike.
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            acc_r     <= 40'sh0000000000;
            elapsed_r <= 40'h0000000000;
        end
        else if (cycle_strobe_i)
        begin
            if (close_w)
            begin
                acc_r     <= 40'sh0000000000; // RULE3
                elapsed_r <= 40'h0000000000;
            end
            else
            begin
                acc_r     <= sum_w; // RULE1 RULE11
                elapsed_r <= elapsed_nxt;
            end
        end
    end

    // Serial divide of |sum| * numerator by denominator. It needs 72 clocks, far less than
    // a bus cycle, so the hardware count stays small at the price of a short latency.
    assign den_w    = (cfg_r.denominator == 32'h00000000) ? 32'h00000001 : cfg_r.denominator;
    assign rem_sh_w = {rem_r[31:0], quo_r[71]};

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_r <= EVC_ST_IDLE;
            step_r  <= 7'h00;
            rem_r   <= 33'h000000000;
            quo_r   <= 72'h000000000000000000;
            neg_r   <= 1'b0;
        end
        else
        begin
            case (state_r)
                EVC_ST_IDLE:
                begin
                    if (cycle_strobe_i && close_w)
                    begin
                        quo_r   <= 72'(sum_mag_w) * 72'(cfg_r.numerator); // RULE4
                        neg_r   <= sum_w[39];
                        rem_r   <= 33'h000000000;
                        step_r  <= 7'h00;
                        state_r <= EVC_ST_DIV;
                    end
                end
                EVC_ST_DIV:
                begin
                    if (rem_sh_w >= {1'b0, den_w})
                    begin
                        rem_r <= rem_sh_w - {1'b0, den_w}; // RULE4
                        quo_r <= {quo_r[70:0], 1'b1};
                    end
                    else
                    begin
                        rem_r <= rem_sh_w;
                        quo_r <= {quo_r[70:0], 1'b0};
                    end
                    step_r <= step_r + 7'h01;
                    if (step_r == `EVC_DIV_STEPS - 7'h01)
                    begin
                        state_r <= EVC_ST_IDLE; // RULE10
                    end
                end
                default:
                begin
                    state_r <= EVC_ST_IDLE;
                end
            endcase
        end
    end

    // Scaled velocity, saturated to 32 bits and signed back, taken when the divide finishes.
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            scaled_r <= 32'sh00000000;
        end
        else if (state_r == EVC_ST_IDLE && step_r == `EVC_DIV_STEPS)
        begin
            if (quo_r[71:31] != 41'h00000000000)
            begin
                scaled_r <= neg_r ? 32'sh80000001 : 32'sh7FFFFFFF;
            end
            else
            begin
                scaled_r <= neg_r ? -$signed({1'b0, quo_r[30:0]}) : $signed({1'b0, quo_r[30:0]});
            end
        end
    end

    // First-order low-pass: y += (x - y) >>> n, which is x*2^-n + y*(1 - 2^-n).
    assign level_w     = (cfg_r.filter_sel > `EVC_FILTER_MAX) ? `EVC_FILTER_MAX : cfg_r.filter_sel;
    assign filt_diff_w = 33'(scaled_r) - 33'(velocity_o);
    assign filt_nxt    = 33'(velocity_o) + (filt_diff_w >>> level_w); // RULE8

    // Output advances once per bus cycle; level zero copies the scaled value straight through.
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            velocity_o       <= 32'sh00000000;
            velocity_valid_o <= 1'b0;
        end
        else
        begin
            velocity_valid_o <= cycle_strobe_i; // RULE9
            if (cycle_strobe_i)
            begin
                if (cfg_r.filter_sel == 4'h0)
                begin
                    velocity_o <= scaled_r; // RULE7
                end
                else
                begin
                    velocity_o <= filt_nxt[31:0]; // RULE8 RULE9
                end
            end
        end
    end

    // Status: configured cycle below the least cycle that velocity data needs.
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            short_r <= 1'b0;
        end
        else
        begin
            short_r <= (cycle_ns_i < `EVC_MIN_CYCLE_NS); // RULE10
        end
    end
    assign cycle_short_o = short_r;

    // Checks on the logic above.
    a_restore_defaults: assert property (@(posedge clk_i) disable iff (rst_i) // RULE2
        restore_i |=> (cfg_r.window_ms == `EVC_WINDOW_MS_DEF) && (cfg_r.filter_sel == 4'h0))
        else $error("Restore did not load the default window and filter.");

    a_window_round: assert property (@(posedge clk_i) disable iff (rst_i) // RULE3
        (cycle_strobe_i && !close_w) |=> (elapsed_r < window_ns_w)
            && (elapsed_r != 40'h0000000000 || cycle_ns_i == 32'h00000000))
        else $error("Window closed before its time or time not accumulated.");

    a_accumulate_delta: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
        (cycle_strobe_i && !close_w) |=> acc_r == $past(acc_r) + $past(delta_w))
        else $error("Window sum did not add the cycle delta.");

    a_close_divides: assert property (@(posedge clk_i) disable iff (rst_i) // RULE4
        (cycle_strobe_i && close_w && state_r == EVC_ST_IDLE) |=>
            (state_r == EVC_ST_DIV) ##71 (state_r == EVC_ST_DIV && step_r == 7'h47)
            ##1 (state_r == EVC_ST_IDLE) && (acc_r == 40'sh0000000000 || cycle_strobe_i))
        else $error("Scaling divide did not run for 72 clocks after window close.");

    a_single_sample: assert property (@(posedge clk_i) disable iff (rst_i) // RULE12
        !cycle_strobe_i |=> $stable(prev_pos_r))
        else $error("Position sampled outside a bus cycle strobe.");

    a_manual_ignored: assert property (@(posedge clk_i) disable iff (rst_i) // RULE6
        !cfg_r.manual_res_en |-> res_w == (40'h0000000001 << cfg_r.res_bits))
        else $error("Manual resolution used while disabled.");

    a_delta_folded: assert property (@(posedge clk_i) disable iff (rst_i) // RULE13
        (cycle_strobe_i && have_prev_r) |-> (delta_w >= $signed(half_w) - $signed(res_w))
            && (delta_w < $signed(res_w) - $signed(half_w)))
        else $error("Position delta not folded into half the resolution.");

    a_bypass_filter: assert property (@(posedge clk_i) disable iff (rst_i) // RULE7
        (cycle_strobe_i && cfg_r.filter_sel == 4'h0) |=> velocity_o == $past(scaled_r))
        else $error("Filter level zero did not pass the value through.");

    a_filter_step: assert property (@(posedge clk_i) disable iff (rst_i) // RULE8
        (cycle_strobe_i && cfg_r.filter_sel == 4'h1) |=>
            velocity_o == 32'($past(velocity_o)
                + ((33'($past(scaled_r)) - 33'($past(velocity_o))) >>> 1)))
        else $error("Level one filter step wrong.");

    a_filter_per_cycle: assert property (@(posedge clk_i) disable iff (rst_i) // RULE9
        !cycle_strobe_i |=> $stable(velocity_o) && !velocity_valid_o)
        else $error("Velocity output moved without a bus cycle.");

endmodule : evc_velocity_calc

// ### sim/evc_enc_model.sv
// Acquisition-side model: one encoder position sample per bus cycle tick.
`timescale 1ns/1ns
module evc_enc_model #(
    parameter int PERIOD = 80
) (
    input  wire logic        clk_i,
    input  wire logic        run_i,
    input  wire logic [31:0] step_i,
    input  wire logic [31:0] mod_i,
    output logic             cycle_strobe_o,
    output logic [31:0]      position_o
);
    int          cnt = 0;
    logic [31:0] pos = 32'h00000000;
    logic [31:0] nxt;

    // The position bus carries a toggling pattern between ticks, so a stray sample shows up.
    always @(posedge clk_i)
    begin
        #2;
        cnt = (cnt + 1) % PERIOD;
        cycle_strobe_o = run_i && (cnt == 0);
        nxt = pos + step_i;
        if (mod_i != 32'h00000000 && $signed(nxt) < 0)
            nxt = nxt + mod_i;
        while (mod_i != 32'h00000000 && nxt >= mod_i)
            nxt = nxt - mod_i;
        if (cycle_strobe_o)
            pos = nxt;
        position_o = cycle_strobe_o ? pos : ~position_o;
    end
endmodule : evc_enc_model

// ### sim/evc_velocity_calc_tb.sv
// Self-checking bench for the encoder velocity calculator.
`timescale 1ns/1ns
`define EVC_CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
    $display("unexpected %s: expected %0d, seen %0d", nm, e, g); end end
module evc_velocity_calc_tb
    import evc_pkg::*;
;
    logic               clk_i = 1'b0;
    logic               rst_i = 1'b1;
    logic               run = 1'b0;
    logic [31:0]        step = 32'h00000000;
    logic [31:0]        modv = 32'h00000000;
    logic [31:0]        cycle_ns = 32'h001E8480;
    logic               cfg_we = 1'b0;
    evc_cfg_t           cfg = '0;
    logic               restore = 1'b0;
    logic               cycle_strobe;
    logic [31:0]        position;
    evc_cfg_t           cfg_o;
    logic signed [31:0] velocity;
    logic               valid;
    logic               cycle_short;
    int                 n_fail = 0;
    int                 n_tests = 0;
    evc_cfg_t           dflt;
    evc_cfg_t           c;
    logic signed [31:0] y;
    logic signed [31:0] v;

    localparam logic [31:0] MS2 = 32'h001E8480;
    localparam logic [31:0] MS3 = 32'h002DC6C0;

    // Free-running 50 MHz clock.
    always #10 clk_i = ~clk_i;

    evc_enc_model i_evc_enc_model (
        .clk_i          (clk_i),
        .run_i          (run),
        .step_i         (step),
        .mod_i          (modv),
        .cycle_strobe_o (cycle_strobe),
        .position_o     (position)
    );

    evc_velocity_calc i_evc_velocity_calc (
        .clk_i            (clk_i),
        .rst_i            (rst_i),
        .cycle_strobe_i   (cycle_strobe),
        .position_i       (position),
        .cycle_ns_i       (cycle_ns),
        .cfg_we_i         (cfg_we),
        .cfg_i            (cfg),
        .restore_i        (restore),
        .cfg_o            (cfg_o),
        .velocity_o       (velocity),
        .velocity_valid_o (valid),
        .cycle_short_o    (cycle_short)
    );

    task automatic final_report;
        $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : final_report

    task automatic write_cfg(input evc_cfg_t cv);
        @(posedge clk_i);
        #2;
        cfg = cv;
        cfg_we = 1'b1;
        @(posedge clk_i);
        #2;
        cfg_we = 1'b0;
        `EVC_CHK("cfg_o", cv, cfg_o)
    endtask : write_cfg

    // One bus cycle: the valid pulse must follow the tick by one clock and last one clock.
    task automatic tick(output logic signed [31:0] vo);
        @(negedge cycle_strobe);
        #5;
        `EVC_CHK("velocity_valid_o", 1'b1, valid)
        vo = velocity;
        @(posedge clk_i);
        #2;
        `EVC_CHK("velocity_valid_o end", 1'b0, valid)
    endtask : tick

    // Sixteen cycles cover three whole windows, so the last value is the steady one.
    task automatic meas(input evc_cfg_t cv, input logic [31:0] cyc, input int d,
                        input logic [31:0] m, input int exp);
        logic signed [31:0] vv;
        write_cfg(cv);
        cycle_ns = cyc;
        step = d;
        modv = m;
        repeat (16) tick(vv);
        `EVC_CHK("velocity_o", exp, vv)
    endtask : meas

    // Main sequence.
    initial
    begin
        dflt = '{16'h000A, 32'h00000001, 32'h00000001, 4'h0, 32'h00000000, 1'b0, 6'h19};
        repeat (10) @(posedge clk_i);
        #2;
        rst_i = 1'b0;
        `EVC_CHK("cfg_o reset", dflt, cfg_o)
        `EVC_CHK("velocity_o reset", 32'sh00000000, velocity)
        run = 1'b1;
        c = dflt;
        meas(c, MS2, 7, 32'h00000000, 35);
        meas(c, MS3, 7, 32'h00000000, 28);
        c.numerator = 32'h00000003;
        c.denominator = 32'h00000002;
        meas(c, MS3, 7, 32'h00000000, 42);
        c.numerator = 32'h00000001;
        c.denominator = 32'h00000003;
        meas(c, MS3, -7, 32'h00000000, -9);
        c = dflt;
        c.window_ms = 16'h0007;
        meas(c, MS2, 5, 32'h00000000, 20);
        // Counter wraps at the power-of-two and at the manual resolution.
        c = dflt;
        c.res_bits = 6'h08;
        meas(c, MS2, 7, 32'h00000100, 35);
        c.res_bits = 6'h0A;
        c.manual_res = 32'h000003E8;
        meas(c, MS2, -7, 32'h00000400, -35);
        c.manual_res_en = 1'b1;
        meas(c, MS2, 9, 32'h000003E8, 45);
        // Every filter level, and one above the top that must act as the top level.
        for (int n = 1; n <= 9; n++)
        begin
            c = dflt;
            c.numerator = 32'h00000064;
            meas(c, MS2, 50, 32'h00000000, 25000);
            c.filter_sel = 4'(n);
            write_cfg(c);
            step = 32'h00000000;
            repeat (12) tick(y);
            repeat (6)
            begin
                tick(v);
                `EVC_CHK("filtered velocity_o", y + ((-y) >>> (n > 8 ? 8 : n)), v)
                y = v;
            end
        end
        // Status flag for a bus cycle below the supported minimum.
        cycle_ns = 32'h000F4240;
        repeat (3) @(posedge clk_i);
        #2;
        `EVC_CHK("cycle_short_o", 1'b1, cycle_short)
        cycle_ns = 32'h00124F80;
        repeat (3) @(posedge clk_i);
        #2;
        `EVC_CHK("cycle_short_o", 1'b0, cycle_short)
        // Restore in the same cycle as a write must win.
        @(posedge clk_i);
        #2;
        cfg_we = 1'b1;
        restore = 1'b1;
        @(posedge clk_i);
        #2;
        cfg_we = 1'b0;
        restore = 1'b0;
        `EVC_CHK("cfg_o restore", dflt, cfg_o)
        final_report();
    end

    // Watchdog: the sequence needs about 35000 clocks.
    initial
    begin
        #1500000;
        n_fail++;
        final_report();
    end
endmodule : evc_velocity_calc_tb
